// ---- hw/usb_event_map.vh ----
`ifndef USB_EVENT_MAP_VH
`define USB_EVENT_MAP_VH

// Register bus geometry.
`define AXI_AW 8
`define AXI_DW 32
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Register byte offsets.
`define REG_FLAGS 8'h00
`define REG_MASK 8'h04
`define REG_CTRL 8'h08
`define REG_ERREN 8'h0C
`define REG_LINE 8'h10

// Field widths and reset values.
`define FLAG_W 8
`define ERR_W 8
`define FLAG_RST 8'h00
`define MASK_RST 8'h00
`define CTRL_RST 8'h00
`define ERREN_RST 8'h00
`define UPPER_ZERO 24'h000000
`define LINE_PAD 29'h00000000

// Flag bit positions in usb_event_flags.
`define BIT_STALL 7
`define BIT_ATTACH 6
`define BIT_RESUME 5
`define BIT_IDLE 4
`define BIT_TRN 3
`define BIT_FRAME 2
`define BIT_ERR 1
`define BIT_RST 0

// Control register field.
`define BIT_HOST_ROLE_ENABLE 3

// Line timer limits in 4 ns clock cycles: 2.5 us, 2.5 us and 3 ms.
`define CNT_W 20
`define KSTATE_CYC 20'h00271
`define LINE_CYC 20'h00271
`define IDLE_CYC 20'hB71B0

`endif

// ---- hw/usb_line_sync.v ----
`timescale 1ns/10ps
`default_nettype none

module usb_line_sync (
  // Clock and reset.
  input wire clk_i,
  input wire rstn_i,
  // Raw pin levels and their synchronised copies.
  input wire dp_i,
  input wire dm_i,
  output reg dp_o,
  output reg dm_o
);

  reg dp_meta_q;
  reg dm_meta_q;

  // Two flops per pin; the first is read only by the second.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dp_meta_q <= 1'h0;
      dm_meta_q <= 1'h0;
      dp_o <= 1'h0;
      dm_o <= 1'h0;
    end else begin
      dp_meta_q <= dp_i;
      dm_meta_q <= dm_i;
      dp_o <= dp_meta_q;
      dm_o <= dm_meta_q;
    end
  end

endmodule // usb_line_sync

`default_nettype wire

// ---- hw/usb_interrupt_flag_bank.v ----
// What this block does
// - Flag register upper 24 bits read zero.
// - Hardware sets flags; writing one clears them.
// - Host role: received STALL sets bit 7.
// - Peripheral role: sent STALL sets bit 7.
// - Detected peripheral attach sets bit 6.
// - Attach needs host, 2.5 us quiet, no SE0.
// - K-state held 2.5 us sets bit 5.
// - Idle bus for 3 ms sets bit 4.
// - Finished token processing sets bit 3.
// - Clearing bit 3 advances the status FIFO.
// - Unmasked error condition sets bit 1.
// - Only enabled error sources reach bit 1.
// - Peripheral role: valid bus reset sets bit 0.
// - Host role: peripheral detach sets bit 0.
// - Host-enable bit selects host or peripheral role.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "usb_event_map.vh"

module usb_interrupt_flag_bank #(
  parameter [`CNT_W-1:0] IDLE_CYCLES = `IDLE_CYC
) (
  // Clock and reset.
  input wire clk_i,
  input wire rstn_i,
  // AXI4-Lite write address and data.
  input wire [`AXI_AW-1:0] awaddr_i,
  input wire awvalid_i,
  output reg awready_o,
  input wire [`AXI_DW-1:0] wdata_i,
  input wire [3:0] wstrb_i,
  input wire wvalid_i,
  output reg wready_o,
  // AXI4-Lite write response.
  output reg [1:0] bresp_o,
  output reg bvalid_o,
  input wire bready_i,
  // AXI4-Lite read.
  input wire [`AXI_AW-1:0] araddr_i,
  input wire arvalid_i,
  output reg arready_o,
  output reg [`AXI_DW-1:0] rdata_o,
  output reg [1:0] rresp_o,
  output reg rvalid_o,
  input wire rready_i,
  // USB line pins.
  input wire dp_i,
  input wire dm_i,
  // Events from the transaction engine.
  input wire stall_rx_i,
  input wire stall_tx_i,
  input wire token_done_i,
  input wire sof_rx_i,
  input wire frame_thresh_i,
  input wire bus_reset_i,
  input wire [`ERR_W-1:0] err_src_i,
  // Outputs to the system.
  output reg stat_fifo_pop_o,
  output reg host_role_o,
  output reg irq_o
);

  localparam [`CNT_W-1:0] KSTATE_LIM = `KSTATE_CYC;
  localparam [`CNT_W-1:0] LINE_LIM = `LINE_CYC;
  localparam [`CNT_W-1:0] CNT_ONE = 20'h00001;
  localparam [`CNT_W-1:0] CNT_ZERO = 20'h00000;

  reg [`FLAG_W-1:0] flags_q;
  reg [`FLAG_W-1:0] flags_d;
  reg [`FLAG_W-1:0] mask_q;
  reg [`FLAG_W-1:0] ctrl_q;
  reg [`ERR_W-1:0] erren_q;
  reg [`FLAG_W-1:0] set_ev;
  reg [`FLAG_W-1:0] clr_ev;
  reg [`AXI_AW-1:0] awaddr_q;
  reg [`FLAG_W-1:0] wbyte_q;
  reg wstrb0_q;
  reg aw_full_q;
  reg w_full_q;
  reg aw_full_d;
  reg w_full_d;
  reg bvalid_d;
  reg rvalid_d;
  reg wr_go;
  reg [`AXI_DW-1:0] rd_word;
  reg host_prev_q;
  reg attached_q;
  reg [`CNT_W-1:0] kstate_cnt_q;
  reg [`CNT_W-1:0] idle_cnt_q;
  reg [`CNT_W-1:0] line_cnt_q;
  wire dp_s;
  wire dm_s;
  wire host_en;
  wire host_chg;
  wire line_se0;
  wire line_j;
  wire line_k;
  wire line_want;
  wire resume_ev;
  wire idle_ev;
  wire line_ev;
  wire ar_hs;
  wire flag_wr;

  // Drops the byte-lane bits of an address.
  function [`AXI_AW-1:0] align;
    input [`AXI_AW-1:0] a;
    begin
      align = {a[`AXI_AW-1:2], 2'h0};
    end
  endfunction

  // Returns nonzero when the address hits a mapped register.
  function map_hit;
    input [`AXI_AW-1:0] a;
    reg [`AXI_AW-1:0] w;
    begin
      w = {a[`AXI_AW-1:2], 2'h0};
      map_hit = (w == `REG_FLAGS) || (w == `REG_MASK) ||
        (w == `REG_CTRL) || (w == `REG_ERREN) || (w == `REG_LINE);
    end
  endfunction

  // Counts while cond holds, saturating at lim; clears otherwise.
  function [`CNT_W-1:0] bump;
    input [`CNT_W-1:0] c;
    input cond;
    input [`CNT_W-1:0] lim;
    begin
      if (!cond)
        bump = CNT_ZERO;
      else if (c < lim)
        bump = c + CNT_ONE;
      else
        bump = c;
    end
  endfunction

  // Gives a one-cycle hit as the counter reaches its limit.
  function reach;
    input [`CNT_W-1:0] c;
    input cond;
    input [`CNT_W-1:0] lim;
    begin
      reach = cond && (c == lim - CNT_ONE);
    end
  endfunction

  usb_line_sync u_line_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .dp_i(dp_i),
    .dm_i(dm_i),
    .dp_o(dp_s),
    .dm_o(dm_s)
  );

  assign host_en = ctrl_q[`BIT_HOST_ROLE_ENABLE];
  assign host_chg = host_en ^ host_prev_q;
  assign line_se0 = ~dp_s & ~dm_s;
  assign line_j = dp_s & ~dm_s;
  assign line_k = ~dp_s & dm_s;
  // Detached waits for a steady non-SE0 line; attached waits for SE0.
  assign line_want = host_en & ~host_chg & (attached_q ? line_se0 :
    ~line_se0);
  assign resume_ev = reach(kstate_cnt_q, line_k, KSTATE_LIM);
  assign idle_ev = reach(idle_cnt_q, line_j, IDLE_CYCLES);
  assign line_ev = reach(line_cnt_q, line_want, LINE_LIM);
  assign ar_hs = arvalid_i & arready_o;
  assign flag_wr = wr_go & wstrb0_q & (align(awaddr_q) == `REG_FLAGS);

  // Line-state timers.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      kstate_cnt_q <= CNT_ZERO;
      idle_cnt_q <= CNT_ZERO;
      line_cnt_q <= CNT_ZERO;
    end else begin
      kstate_cnt_q <= bump(kstate_cnt_q, line_k, KSTATE_LIM);
      idle_cnt_q <= bump(idle_cnt_q, line_j, IDLE_CYCLES);
      line_cnt_q <= bump(line_cnt_q, line_want, LINE_LIM);
    end
  end

  // Attach state; a role change restarts the host-side logic.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      attached_q <= 1'h0;
      host_prev_q <= 1'h0;
    end else begin
      host_prev_q <= host_en;
      if (host_chg || !host_en)
        attached_q <= 1'h0;
      else if (line_ev)
        attached_q <= ~attached_q;
    end
  end

  // Event sources per flag, steered by the role.
  always @* begin
    set_ev = `FLAG_RST;
    set_ev[`BIT_STALL] = host_en ? stall_rx_i : stall_tx_i;
    set_ev[`BIT_ATTACH] = line_ev & ~attached_q;
    set_ev[`BIT_RESUME] = resume_ev;
    set_ev[`BIT_IDLE] = idle_ev;
    set_ev[`BIT_TRN] = token_done_i;
    set_ev[`BIT_FRAME] = host_en ? frame_thresh_i : sof_rx_i;
    set_ev[`BIT_ERR] = |(err_src_i & erren_q);
    set_ev[`BIT_RST] = host_en ? (line_ev & attached_q) :
      bus_reset_i;
    clr_ev = flag_wr ? wbyte_q : `FLAG_RST;
    // A set in the same cycle as its clear wins.
    flags_d = (flags_q & ~clr_ev) | set_ev;
  end

  // Flag register, status FIFO pop and interrupt line.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q <= `FLAG_RST;
      stat_fifo_pop_o <= 1'h0;
      irq_o <= 1'h0;
      host_role_o <= 1'h0;
    end else begin
      flags_q <= flags_d;
      stat_fifo_pop_o <= clr_ev[`BIT_TRN] & flags_q[`BIT_TRN];
      irq_o <= |(flags_d & mask_q);
      host_role_o <= host_en;
    end
  end

  // Write channel bookkeeping.
  always @* begin
    aw_full_d = aw_full_q | (awvalid_i & awready_o);
    w_full_d = w_full_q | (wvalid_i & wready_o);
    wr_go = aw_full_q & w_full_q & ~bvalid_o;
    if (wr_go) begin
      aw_full_d = 1'h0;
      w_full_d = 1'h0;
    end
    bvalid_d = wr_go | (bvalid_o & ~bready_i);
    rvalid_d = ar_hs | (rvalid_o & ~rready_i);
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_full_q <= 1'h0;
      w_full_q <= 1'h0;
      awready_o <= 1'h0;
      wready_o <= 1'h0;
      bvalid_o <= 1'h0;
      bresp_o <= `RESP_OKAY;
      awaddr_q <= `FLAG_RST;
      wbyte_q <= `FLAG_RST;
      wstrb0_q <= 1'h0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_o <= ~aw_full_d & ~bvalid_d;
      wready_o <= ~w_full_d & ~bvalid_d;
      bvalid_o <= bvalid_d;
      if (awvalid_i && awready_o)
        awaddr_q <= awaddr_i;
      if (wvalid_i && wready_o) begin
        wbyte_q <= wdata_i[`FLAG_W-1:0];
        wstrb0_q <= wstrb_i[0];
      end
      if (wr_go)
        bresp_o <= map_hit(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // Software-written registers; only byte lane 0 is implemented.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_q <= `MASK_RST;
      ctrl_q <= `CTRL_RST;
      erren_q <= `ERREN_RST;
    end else if (wr_go && wstrb0_q) begin
      if (align(awaddr_q) == `REG_MASK)
        mask_q <= wbyte_q;
      else if (align(awaddr_q) == `REG_CTRL)
        ctrl_q <= wbyte_q;
      else if (align(awaddr_q) == `REG_ERREN)
        erren_q <= wbyte_q;
    end
  end

  // Read data multiplexer.
  always @* begin
    rd_word = {`UPPER_ZERO, `FLAG_RST};
    if (align(araddr_i) == `REG_FLAGS)
      rd_word = {`UPPER_ZERO, flags_q};
    else if (align(araddr_i) == `REG_MASK)
      rd_word = {`UPPER_ZERO, mask_q};
    else if (align(araddr_i) == `REG_CTRL)
      rd_word = {`UPPER_ZERO, ctrl_q};
    else if (align(araddr_i) == `REG_ERREN)
      rd_word = {`UPPER_ZERO, erren_q};
    else if (align(araddr_i) == `REG_LINE)
      rd_word = {`LINE_PAD, attached_q, dp_s, dm_s};
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arready_o <= 1'h0;
      rvalid_o <= 1'h0;
      rdata_o <= {`UPPER_ZERO, `FLAG_RST};
      rresp_o <= `RESP_OKAY;
    end else begin
      arready_o <= ~rvalid_d;
      rvalid_o <= rvalid_d;
      if (ar_hs) begin
        rdata_o <= rd_word;
        rresp_o <= map_hit(araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

endmodule // usb_interrupt_flag_bank

`default_nettype wire

// ---- verification/usb_link_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
module usb_link_partner (
  // Line state from the bench: 0 J, 1 K, 2 SE0.
  input wire logic [1:0] line_sel_i,
  // Line levels.
  output logic dp_o,
  output logic dm_o
);
  assign dp_o = (line_sel_i == 2'h0);
  assign dm_o = (line_sel_i == 2'h1);
endmodule // usb_link_partner
`default_nettype wire

// ---- verification/usb_interrupt_flag_bank_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module usb_interrupt_flag_bank_props (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register bus.
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] rresp_o,
  input wire logic rvalid_o,
  input wire logic awready_o,
  input wire logic wready_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  // System outputs.
  input wire logic stat_fifo_pop_o,
  input wire logic host_role_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_ar;
    arvalid_i && arready_o;
  endsequence
  sequence s_b;
    bvalid_o && bready_i;
  endsequence
  property p_rst;
    $rose(rstn_i) |-> !irq_o && !host_role_o && !stat_fifo_pop_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle");
  property p_rd_lat;
    s_ar |=> rvalid_o && !arready_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("late read");
  property p_rd_upper;
    rvalid_o |-> rdata_o[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper bits");
  property p_unmap;
    s_ar ##0 araddr_i > 8'h13 |=> rresp_o == 2'h2;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped okay");
  property p_b_done;
    s_b |=> !bvalid_o;
  endproperty
  a_b_done: assert property (p_b_done) else $error("response stuck");
  property p_aw_block;
    bvalid_o |-> !awready_o && !wready_o;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write early");
  property p_role;
    $changed(host_role_o) |-> bvalid_o || $past(bvalid_o);
  endproperty
  a_role: assert property (p_role) else $error("role moved");
  property p_pop;
    stat_fifo_pop_o |-> (bvalid_o || $past(bvalid_o)) ##1 !stat_fifo_pop_o;
  endproperty
  a_pop: assert property (p_pop) else $error("bad pop");
endmodule // usb_interrupt_flag_bank_props
bind usb_interrupt_flag_bank usb_interrupt_flag_bank_props props_u (
  .clk_i, .rstn_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o,
  .rvalid_o, .awready_o, .wready_o, .bvalid_o, .bready_i, .stat_fifo_pop_o,
  .host_role_o, .irq_o);
`default_nettype wire

// ---- verification/usb_interrupt_flag_bank_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module usb_interrupt_flag_bank_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0] wstrb_i = 4'hF;
  logic awvalid_i = 0, wvalid_i = 0, bready_i = 0, arvalid_i = 0, rready_i = 0;
  logic [5:0] ev = 6'h00;
  logic [7:0] err_src_i = 8'h00;
  logic [1:0] line_sel = 2'h2;
  wire awready_o, wready_o, bvalid_o, arready_o, rvalid_o, dp, dm;
  wire stat_fifo_pop_o, host_role_o, irq_o;
  wire [1:0] bresp_o, rresp_o;
  wire [31:0] rdata_o;
  int mismatches = 0, checked = 0, cyc = 0;
  logic [7:0] exp_p [6] = '{8'h00, 8'h80, 8'h08, 8'h04, 8'h00, 8'h01};
  logic [7:0] exp_h [6] = '{8'h80, 8'h00, 8'h08, 8'h00, 8'h04, 8'h00};
  usb_interrupt_flag_bank #(.IDLE_CYCLES(20'd40)) dut_u (.*, .dp_i(dp),
    .dm_i(dm), .stall_rx_i(ev[0]), .stall_tx_i(ev[1]), .token_done_i(ev[2]),
    .sof_rx_i(ev[3]), .frame_thresh_i(ev[4]), .bus_reset_i(ev[5]));
  usb_link_partner link_u (.line_sel_i(line_sel), .dp_o(dp), .dm_o(dm));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
      if (bvalid_o) break;
    end
    chk(bresp_o, (a > 8'h13) ? 32'h2 : 32'h0);
    bready_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arready_o) arvalid_i <= 1'b0;
      if (rvalid_o) break;
    end
    chk(rdata_o, e);
    chk(rresp_o, (a > 8'h13) ? 32'h2 : 32'h0);
    rready_i <= 1'b0;
  endtask
  task automatic pulse(input logic [5:0] e, input logic [7:0] r);
    @(posedge clk_i);
    ev <= e;
    err_src_i <= r;
    @(posedge clk_i);
    ev <= 6'h00;
    err_src_i <= 8'h00;
  endtask
  task automatic line(input logic [1:0] s, input int n);
    line_sel <= s;
    repeat (n) @(posedge clk_i);
  endtask
  task automatic t_rst();
    for (int i = 0; i < 5; i++) rc(8'(i * 4), 32'h0);
    wr(8'h20, 32'hFF);
    rc(8'h20, 32'h0);
    rc(8'h00, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_role(input logic h);
    logic [7:0] e;
    wr(8'h08, {28'h0, h, 3'h0});
    repeat (2) @(posedge clk_i);
    chk(host_role_o, h);
    for (int i = 0; i < 6; i++) begin
      e = h ? exp_h[i] : exp_p[i];
      pulse(6'h01 << i, 8'h00);
      rc(8'h00, e);
      chk(irq_o, e != 8'h00);
      wr(8'h00, 32'hFF);
    end
    $display("role %0d test done", h);
  endtask
  task automatic t_err();
    pulse(6'h00, 8'h04);
    rc(8'h00, 32'h0);
    wr(8'h0C, 32'h04);
    pulse(6'h00, 8'h04);
    wr(8'h00, 32'h0);
    rc(8'h00, 32'h02);
    wr(8'h04, 32'h0);
    rc(8'h00, 32'h02);
    chk(irq_o, 0);
    wr(8'h04, 32'hFF);
    wr(8'h00, 32'h02);
    rc(8'h00, 32'h0);
    $display("error test done");
  endtask
  task automatic t_pop();
    logic [31:0] seen;
    for (int k = 0; k < 2; k++) begin
      seen = 0;
      pulse(6'h04, 8'h00);
      fork
        wr(8'h00, k ? 32'h08 : 32'h0);
        repeat (12) begin
          @(posedge clk_i);
          seen += stat_fifo_pop_o;
        end
      join
      chk(seen, k);
    end
    $display("fifo test done");
  endtask
  task automatic t_line();
    wr(8'h04, 32'hDF);
    line(1, 300);
    line(2, 10);
    rc(8'h00, 32'h0);
    line(1, 700);
    line(2, 10);
    rc(8'h00, 32'h20);
    chk(irq_o, 1'b0);
    wr(8'h00, 32'hFF);
    line(0, 700);
    line(2, 10);
    rc(8'h00, 32'h10);
    chk(irq_o, 1'b1);
    wr(8'h08, 32'h08);
    wr(8'h00, 32'hFF);
    line(0, 700);
    line(2, 10);
    rc(8'h10, 32'h4);
    rc(8'h00, 32'h50);
    wr(8'h00, 32'hFF);
    line(2, 700);
    rc(8'h00, 32'h01);
    $display("line test done");
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_rst();
    wr(8'h04, 32'hFF);
    t_role(1'b0);
    t_role(1'b1);
    wr(8'h08, 32'h0);
    t_err();
    t_pop();
    t_line();
    close_out();
  end
endmodule // usb_interrupt_flag_bank_tb
`default_nettype wire
